// ===== shared/pcm_defs.vh
// Constants for the pulse counter and rate monitor block
`ifndef PCM_DEFS_VH
`define PCM_DEFS_VH

// ********************
// Timing
// ********************
// 0.1 s tick and 1/30 s slow window at 20 MHz; blip and gate in ticks
`define PCM_TICK_CYC 24'h1E8480
`define PCM_SLOW_CYC 24'h0A2C2B
`define PCM_BLIP_T 8'h05
`define PCM_GATE_T 8'h0A

// ********************
// Register byte addresses
// ********************
`define PCM_A_CTRL 8'h00
`define PCM_A_MODE 8'h04
`define PCM_A_SP1 8'h08
`define PCM_A_SP2 8'h0C
`define PCM_A_HI1 8'h10
`define PCM_A_LO1 8'h14
`define PCM_A_HI2 8'h18
`define PCM_A_LO2 8'h1C
`define PCM_A_HYS 8'h20
`define PCM_A_PRE 8'h24
`define PCM_A_POST 8'h28
`define PCM_A_RDEL 8'h2C
`define PCM_A_DLY 8'h30
`define PCM_A_RT 8'h34
`define PCM_A_SETPOINT_EVENTS_COUNTING 8'h38
`define PCM_A_CNT2 8'h3C
`define PCM_A_STAT 8'h40
`define PCM_A_RATE 8'h44
`define PCM_A_REM 8'h48
`define PCM_A_RETX 8'h4C
`define PCM_A_PROG 8'h50

// ********************
// Control and mode fields
// ********************
`define PCM_C_CLR1 0
`define PCM_C_CLR2 1
`define PCM_C_RESTORE 2
`define PCM_M_FUN1 1:0
`define PCM_M_SECOND_CHANNEL_FUNCTION 4:2
`define PCM_M_POL1 8
`define PCM_M_POL2 9
`define PCM_M_BLIP1 10
`define PCM_M_BLIP2 11
`define PCM_M_RSTEN1 12
`define PCM_M_RSTEN2 13
`define PCM_M_LATEN1 14
`define PCM_M_LATEN2 15
`define PCM_M_HIEN1 16
`define PCM_M_LOEN1 17
`define PCM_M_HIEN2 18
`define PCM_M_LOEN2 19
`define PCM_M_INDI 20
`define PCM_M_SAVE 21
`define PCM_M_SLOW 22
`define PCM_M_OPEN 23
`define PCM_LO 15:0
`define PCM_HI 31:16

// ********************
// Function codes
// ********************
`define PCM_FN_COUNT 2'h0
`define PCM_FN_RPM 2'h1
`define PCM_FN_FREQ 2'h2
`define PCM_FN_PPH 2'h3
`define PCM_F2_COUNT 3'h0
`define PCM_F2_SETPTS 3'h1
`define PCM_RPM_MUL 32'h0000003C
`define PCM_PPH_MUL 32'h00000E10

// ********************
// Defaults
// ********************
`define PCM_D_MODE 32'h0030F300
`define PCM_D_SP 32'h00000001
`define PCM_D_LIM 32'h00000000
`define PCM_D_ONES 32'h00010001
`define PCM_D_RDEL 32'h00000000
`define PCM_D_DLY 32'h00000000
`define PCM_D_RT 32'h03E80000

// ********************
// Retransmit, display and bus responses
// ********************
`define PCM_UA_LO 16'h0FA0
`define PCM_UA_HI 16'h4E20
`define PCM_UA_SPAN 32'h00003E80
`define PCM_REM_MIN 32'hFFFFFC19
`define PCM_RESP_OK 2'b00
`define PCM_RESP_ERR 2'b11

`endif

// ===== rtl/pcm_top.v
// Pulse counter and pulse rate monitor, two channels, AXI4-Lite registers
//
// How it works
// - Clear commands zero the first or second counter.
// - Counting: relay changes state at setpoint, held until reset event.
// - Rate: above upper limit trips; recovers below limit minus hysteresis.
// - Rate: below lower limit trips; recovers above limit plus hysteresis.
// - Hysteresis, default one, sets the recovery distance past a limit.
// - With latch enabled, held latch input blocks recovery from a trip.
// - Counter advances only after pre-scale qualified pulses, default one.
// - Each pre-scale completion adds the post-scale amount, default one.
// - Polarity, default close, picks energise or de-energise at setpoint.
// - Relay is a half-second blip or continuous; blip never clears count.
// - Reset delay clears count and relay after setpoint, like reset pin.
// - Per-channel enable decides whether the reset pin clears its count.
// - Second channel may count input pulses with its own scalers.
// - Second channel may count first-channel setpoint arrivals instead.
// - Rate monitoring waits for start-up delay after power-up.
// - A fault must persist for the reaction delay before tripping.
// - Fault indication setting gates the high, low and latched messages.
// - Save enable stores counts and pre-scale progress at power loss.
// - Slow input mode limits accepted pulses to 30 Hz.
// - Pulse type picks contact closing or opening edge.
// - Retransmit maps offset to 4 mA and offset plus span to 20 mA.
// - Factory restore returns every setting to its default.
// - Latch release restarts the start-up delay.
// - Reset delay spans 0.1 to 99.9 seconds in tenths; here any 16-bit value, up to 6553.5 s.
// - Remaining count is setpoint minus count, floored at -999.
// - Rate function on channel one forces channel two to match.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "pcm_defs.vh"

module pcm_top #(
   parameter [23:0] TICK_CYC = `PCM_TICK_CYC,
   parameter [23:0] SLOW_CYC = `PCM_SLOW_CYC
) (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // AXI4-Lite write
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Field pins, high means contact shorted
   input wire pulse_in,
   input wire ctrl_pin_in,
   input wire pwr_fail_in,
   // Outputs
   output wire relay1_out,
   output wire relay2_out,
   output reg [15:0] retx_ua_ff,
   output reg [5:0] fault_disp_ff,
   output reg nv_store_ff,
   output wire [15:0] nv_count1,
   output wire [15:0] nv_count2,
   output wire [31:0] nv_prog
);

localparam [7:0] BLIP_T = `PCM_BLIP_T;
localparam [7:0] GATE_T = `PCM_GATE_T;

function [31:0] pcm_merge;
   input [31:0] old;
   input [31:0] dat;
   input [3:0] strb;
   integer i;
   begin
      pcm_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
         if (strb[i]) begin
            pcm_merge[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
   end
endfunction

function pcm_pre_done;
   input [15:0] prog;
   input [15:0] pre;
   begin
      pcm_pre_done = ({1'b0, prog} + 17'h00001) >= {1'b0, pre};
   end
endfunction

// Returns {high fault, low fault}; when tripped the bands widen by hys
function [1:0] pcm_fault;
   input [31:0] rate;
   input [15:0] hi;
   input [15:0] lo;
   input [15:0] hys;
   input hien;
   input loen;
   input trip;
   reg [32:0] r;
   begin
      r = {1'b0, rate};
      pcm_fault[1] = hien & (trip ? (r + {17'h0, hys}) > {17'h0, hi} :
                                    r > {17'h0, hi});
      pcm_fault[0] = loen & (trip ? r < ({17'h0, lo} + {17'h0, hys}) :
                                    r < {17'h0, lo});
   end
endfunction

// ********************
// Register bus
// ********************
reg aw_got_ff, w_got_ff;
reg [7:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg [31:0] mode_ff, sp1_ff, sp2_ff, hi1_ff, lo1_ff, hi2_ff, lo2_ff;
reg [31:0] hys_ff, pre_ff, post_ff, rdel_ff, dly_ff, rt_ff;
reg [15:0] setpoint_events_counting_ff, cnt2_ff, prog1_ff, prog2_ff;
reg [31:0] rate_ff, rd_val;
reg rd_ok;
wire [31:0] status, remain;

wire wr_go = aw_got_ff & w_got_ff & ~s_axi_bvalid;
wire wr_ctrl = wr_go & (awaddr_ff == `PCM_A_CTRL);
wire wr_setpoint_events_counting = wr_go & (awaddr_ff == `PCM_A_SETPOINT_EVENTS_COUNTING);
wire wr_cnt2 = wr_go & (awaddr_ff == `PCM_A_CNT2);
wire wr_prog = wr_go & (awaddr_ff == `PCM_A_PROG);
wire [31:0] wmask = pcm_merge(32'h00000000, wdata_ff, wstrb_ff);
wire clr1 = wr_ctrl & wmask[`PCM_C_CLR1];
wire clr2 = wr_ctrl & wmask[`PCM_C_CLR2];
wire restore = wr_ctrl & wmask[`PCM_C_RESTORE];

assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
assign s_axi_wready = ~w_got_ff & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCM_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PCM_RESP_OK;
      s_axi_rdata <= 32'h00000000;
   end else begin
      if (s_axi_awvalid & s_axi_awready) begin
         aw_got_ff <= 1'b1;
         awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         w_got_ff <= 1'b1;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         s_axi_bvalid <= 1'b1;
         // Read-only and unmapped words answer with an error
         s_axi_bresp <= (awaddr_ff > `PCM_A_PROG ||
                         awaddr_ff[1:0] != 2'h0 ||
                         (awaddr_ff >= `PCM_A_STAT &&
                          awaddr_ff <= `PCM_A_RETX)) ?
                        `PCM_RESP_ERR : `PCM_RESP_OK;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? `PCM_RESP_OK : `PCM_RESP_ERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
end

always @* begin
   rd_ok = 1'b1;
   if (s_axi_araddr == `PCM_A_CTRL) rd_val = 32'h00000000;
   else if (s_axi_araddr == `PCM_A_MODE) rd_val = mode_ff;
   else if (s_axi_araddr == `PCM_A_SP1) rd_val = sp1_ff;
   else if (s_axi_araddr == `PCM_A_SP2) rd_val = sp2_ff;
   else if (s_axi_araddr == `PCM_A_HI1) rd_val = hi1_ff;
   else if (s_axi_araddr == `PCM_A_LO1) rd_val = lo1_ff;
   else if (s_axi_araddr == `PCM_A_HI2) rd_val = hi2_ff;
   else if (s_axi_araddr == `PCM_A_LO2) rd_val = lo2_ff;
   else if (s_axi_araddr == `PCM_A_HYS) rd_val = hys_ff;
   else if (s_axi_araddr == `PCM_A_PRE) rd_val = pre_ff;
   else if (s_axi_araddr == `PCM_A_POST) rd_val = post_ff;
   else if (s_axi_araddr == `PCM_A_RDEL) rd_val = rdel_ff;
   else if (s_axi_araddr == `PCM_A_DLY) rd_val = dly_ff;
   else if (s_axi_araddr == `PCM_A_RT) rd_val = rt_ff;
   else if (s_axi_araddr == `PCM_A_SETPOINT_EVENTS_COUNTING) rd_val = {16'h0000, setpoint_events_counting_ff};
   else if (s_axi_araddr == `PCM_A_CNT2) rd_val = {16'h0000, cnt2_ff};
   else if (s_axi_araddr == `PCM_A_STAT) rd_val = status;
   else if (s_axi_araddr == `PCM_A_RATE) rd_val = rate_ff;
   else if (s_axi_araddr == `PCM_A_REM) rd_val = remain;
   else if (s_axi_araddr == `PCM_A_RETX) rd_val = {16'h0000, retx_ua_ff};
   else if (s_axi_araddr == `PCM_A_PROG) rd_val = {prog2_ff, prog1_ff};
   else begin
      rd_val = 32'h00000000;
      rd_ok = 1'b0;
   end
end

// ********************
// Settings
// ********************
always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      mode_ff <= `PCM_D_MODE;
      sp1_ff <= `PCM_D_SP;
      sp2_ff <= `PCM_D_SP;
      hi1_ff <= `PCM_D_LIM;
      lo1_ff <= `PCM_D_LIM;
      hi2_ff <= `PCM_D_LIM;
      lo2_ff <= `PCM_D_LIM;
      hys_ff <= `PCM_D_ONES;
      pre_ff <= `PCM_D_ONES;
      post_ff <= `PCM_D_ONES;
      rdel_ff <= `PCM_D_RDEL;
      dly_ff <= `PCM_D_DLY;
      rt_ff <= `PCM_D_RT;
   end else if (restore) begin
      mode_ff <= `PCM_D_MODE;
      sp1_ff <= `PCM_D_SP;
      sp2_ff <= `PCM_D_SP;
      hi1_ff <= `PCM_D_LIM;
      lo1_ff <= `PCM_D_LIM;
      hi2_ff <= `PCM_D_LIM;
      lo2_ff <= `PCM_D_LIM;
      hys_ff <= `PCM_D_ONES;
      pre_ff <= `PCM_D_ONES;
      post_ff <= `PCM_D_ONES;
      rdel_ff <= `PCM_D_RDEL;
      dly_ff <= `PCM_D_DLY;
      rt_ff <= `PCM_D_RT;
   end else if (wr_go) begin
      if (awaddr_ff == `PCM_A_MODE)
         mode_ff <= pcm_merge(mode_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_SP1)
         sp1_ff <= pcm_merge(sp1_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_SP2)
         sp2_ff <= pcm_merge(sp2_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_HI1)
         hi1_ff <= pcm_merge(hi1_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_LO1)
         lo1_ff <= pcm_merge(lo1_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_HI2)
         hi2_ff <= pcm_merge(hi2_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_LO2)
         lo2_ff <= pcm_merge(lo2_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_HYS)
         hys_ff <= pcm_merge(hys_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_PRE)
         pre_ff <= pcm_merge(pre_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_POST)
         post_ff <= pcm_merge(post_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_RDEL)
         rdel_ff <= pcm_merge(rdel_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_DLY)
         dly_ff <= pcm_merge(dly_ff, wdata_ff, wstrb_ff);
      else if (awaddr_ff == `PCM_A_RT)
         rt_ff <= pcm_merge(rt_ff, wdata_ff, wstrb_ff);
   end
end

wire rate1 = mode_ff[`PCM_M_FUN1] != `PCM_FN_COUNT;
wire [2:0] second_channel_function = mode_ff[`PCM_M_SECOND_CHANNEL_FUNCTION];
wire rate2 = rate1 | (second_channel_function > `PCM_F2_SETPTS);
wire [1:0] rfun = rate1 ? mode_ff[`PCM_M_FUN1] : second_channel_function[1:0] - 2'h1;

// ********************
// Input qualification and time base
// ********************
reg [2:0] pin_sync_ff;
reg [1:0] ctl_sync_ff;
reg ctl_d_ff, pwr_d_ff, tick_ff;
reg [23:0] tick_cnt_ff, hold_cnt_ff;
wire pin_lvl = pin_sync_ff[1];
wire pin_edge = mode_ff[`PCM_M_OPEN] ? (~pin_lvl & pin_sync_ff[2]) :
                                       (pin_lvl & ~pin_sync_ff[2]);
wire slow_block = mode_ff[`PCM_M_SLOW] & (hold_cnt_ff != 24'h000000);
wire qpulse = pin_edge & ~slow_block;
wire ctl_lvl = ctl_sync_ff[1];
wire ctl_rise = ctl_lvl & ~ctl_d_ff;
wire ctl_fall = ~ctl_lvl & ctl_d_ff;

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      pin_sync_ff <= 3'h0;
      ctl_sync_ff <= 2'h0;
      ctl_d_ff <= 1'b0;
      pwr_d_ff <= 1'b0;
      nv_store_ff <= 1'b0;
      tick_cnt_ff <= 24'h000000;
      tick_ff <= 1'b0;
      hold_cnt_ff <= 24'h000000;
   end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], pulse_in};
      ctl_sync_ff <= {ctl_sync_ff[0], ctrl_pin_in};
      ctl_d_ff <= ctl_lvl;
      pwr_d_ff <= pwr_fail_in;
      nv_store_ff <= pwr_fail_in & ~pwr_d_ff & mode_ff[`PCM_M_SAVE];
      tick_ff <= (tick_cnt_ff == TICK_CYC - 24'h000001);
      tick_cnt_ff <= (tick_cnt_ff == TICK_CYC - 24'h000001) ?
                     24'h000000 : tick_cnt_ff + 24'h000001;
      if (qpulse)
         hold_cnt_ff <= SLOW_CYC - 24'h000001;
      else if (hold_cnt_ff != 24'h000000)
         hold_cnt_ff <= hold_cnt_ff - 24'h000001;
   end
end

// ********************
// Counting channels
// ********************
reg hit1_d_ff, hit2_d_ff;
reg [7:0] blip1_ff, blip2_ff;
reg [15:0] del1_ff, del2_ff;
wire hit1 = ~rate1 & ({16'h0000, setpoint_events_counting_ff} >= sp1_ff);
wire hit2 = ~rate2 & ({16'h0000, cnt2_ff} >= sp2_ff);
wire hit1_rise = hit1 & ~hit1_d_ff;
wire hit2_rise = hit2 & ~hit2_d_ff;
wire exp1 = hit1 & (rdel_ff[`PCM_LO] != 16'h0000) &
            (del1_ff >= rdel_ff[`PCM_LO]);
wire exp2 = hit2 & (rdel_ff[`PCM_HI] != 16'h0000) &
            (del2_ff >= rdel_ff[`PCM_HI]);
wire rst1 = exp1 | (ctl_rise & mode_ff[`PCM_M_RSTEN1] & ~rate1);
wire rst2 = exp2 | (ctl_rise & mode_ff[`PCM_M_RSTEN2] & ~rate2);
wire ev1 = ~rate1 & qpulse;
wire ev2 = ~rate2 & ((second_channel_function == `PCM_F2_SETPTS) ? hit1_rise : qpulse);

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      setpoint_events_counting_ff <= 16'h0000;
      cnt2_ff <= 16'h0000;
      prog1_ff <= 16'h0000;
      prog2_ff <= 16'h0000;
      hit1_d_ff <= 1'b0;
      hit2_d_ff <= 1'b0;
      blip1_ff <= 8'h00;
      blip2_ff <= 8'h00;
      del1_ff <= 16'h0000;
      del2_ff <= 16'h0000;
   end else begin
      hit1_d_ff <= hit1;
      hit2_d_ff <= hit2;
      if (clr1 | rst1) begin
         setpoint_events_counting_ff <= 16'h0000;
         prog1_ff <= 16'h0000;
      end else if (wr_setpoint_events_counting) begin
         setpoint_events_counting_ff <= wmask[`PCM_LO];
      end else if (wr_prog) begin
         prog1_ff <= wmask[`PCM_LO];
      end else if (ev1) begin
         if (pcm_pre_done(prog1_ff, pre_ff[`PCM_LO])) begin
            prog1_ff <= 16'h0000;
            setpoint_events_counting_ff <= setpoint_events_counting_ff + post_ff[`PCM_LO];
         end else begin
            prog1_ff <= prog1_ff + 16'h0001;
         end
      end
      if (clr2 | rst2) begin
         cnt2_ff <= 16'h0000;
         prog2_ff <= 16'h0000;
      end else if (wr_cnt2) begin
         cnt2_ff <= wmask[`PCM_LO];
      end else if (wr_prog) begin
         prog2_ff <= wmask[`PCM_HI];
      end else if (ev2) begin
         if (pcm_pre_done(prog2_ff, pre_ff[`PCM_HI])) begin
            prog2_ff <= 16'h0000;
            cnt2_ff <= cnt2_ff + post_ff[`PCM_HI];
         end else begin
            prog2_ff <= prog2_ff + 16'h0001;
         end
      end
      // The blip only times the relay; the count stays put
      if (hit1_rise)
         blip1_ff <= BLIP_T;
      else if (tick_ff && blip1_ff != 8'h00)
         blip1_ff <= blip1_ff - 8'h01;
      if (hit2_rise)
         blip2_ff <= BLIP_T;
      else if (tick_ff && blip2_ff != 8'h00)
         blip2_ff <= blip2_ff - 8'h01;
      if (!hit1 || rst1)
         del1_ff <= 16'h0000;
      else if (tick_ff)
         del1_ff <= del1_ff + 16'h0001;
      if (!hit2 || rst2)
         del2_ff <= 16'h0000;
      else if (tick_ff)
         del2_ff <= del2_ff + 16'h0001;
   end
end

// ********************
// Rate monitoring
// ********************
reg [15:0] gate_pulses_ff, st_cnt_ff, rc1_ff, rc2_ff;
reg [7:0] gate_ff;
reg trip1_ff, trip2_ff;
reg [1:0] why1_ff, why2_ff;
wire [31:0] mul = (rfun == `PCM_FN_RPM) ? `PCM_RPM_MUL :
                  (rfun == `PCM_FN_PPH) ? `PCM_PPH_MUL : 32'h00000001;
wire [1:0] f1 = pcm_fault(rate_ff, hi1_ff[`PCM_LO], lo1_ff[`PCM_LO],
                          hys_ff[`PCM_LO], mode_ff[`PCM_M_HIEN1],
                          mode_ff[`PCM_M_LOEN1], trip1_ff);
wire [1:0] f2 = pcm_fault(rate_ff, hi2_ff[`PCM_LO], lo2_ff[`PCM_LO],
                          hys_ff[`PCM_HI], mode_ff[`PCM_M_HIEN2],
                          mode_ff[`PCM_M_LOEN2], trip2_ff);
wire mon_on = st_cnt_ff >= dly_ff[`PCM_LO];
wire hold1 = mode_ff[`PCM_M_LATEN1] & ctl_lvl;
wire hold2 = mode_ff[`PCM_M_LATEN2] & ctl_lvl;
wire latch_any = (rate1 & mode_ff[`PCM_M_LATEN1]) |
                 (rate2 & mode_ff[`PCM_M_LATEN2]);

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      gate_pulses_ff <= 16'h0000;
      gate_ff <= 8'h00;
      rate_ff <= 32'h00000000;
      st_cnt_ff <= 16'h0000;
      rc1_ff <= 16'h0000;
      rc2_ff <= 16'h0000;
      trip1_ff <= 1'b0;
      trip2_ff <= 1'b0;
      why1_ff <= 2'h0;
      why2_ff <= 2'h0;
   end else begin
      if (tick_ff && gate_ff == GATE_T - 8'h01) begin
         gate_ff <= 8'h00;
         gate_pulses_ff <= {15'h0000, qpulse};
         rate_ff <= {16'h0000, gate_pulses_ff} * mul;
      end else begin
         if (tick_ff)
            gate_ff <= gate_ff + 8'h01;
         if (qpulse)
            gate_pulses_ff <= gate_pulses_ff + 16'h0001;
      end
      if (ctl_fall & latch_any)
         st_cnt_ff <= 16'h0000;
      else if (tick_ff && !mon_on)
         st_cnt_ff <= st_cnt_ff + 16'h0001;
      if (!rate1) begin
         trip1_ff <= 1'b0;
         rc1_ff <= 16'h0000;
      end else if (!trip1_ff) begin
         if (!(mon_on && f1 != 2'h0)) begin
            rc1_ff <= 16'h0000;
         end else if (rc1_ff >= dly_ff[`PCM_HI]) begin
            trip1_ff <= 1'b1;
            why1_ff <= f1;
         end else if (tick_ff) begin
            rc1_ff <= rc1_ff + 16'h0001;
         end
      end else if (f1 == 2'h0 && !hold1) begin
         trip1_ff <= 1'b0;
         rc1_ff <= 16'h0000;
      end
      if (!rate2) begin
         trip2_ff <= 1'b0;
         rc2_ff <= 16'h0000;
      end else if (!trip2_ff) begin
         if (!(mon_on && f2 != 2'h0)) begin
            rc2_ff <= 16'h0000;
         end else if (rc2_ff >= dly_ff[`PCM_HI]) begin
            trip2_ff <= 1'b1;
            why2_ff <= f2;
         end else if (tick_ff) begin
            rc2_ff <= rc2_ff + 16'h0001;
         end
      end else if (f2 == 2'h0 && !hold2) begin
         trip2_ff <= 1'b0;
         rc2_ff <= 16'h0000;
      end
   end
end

// ********************
// Relays, display and retransmit
// ********************
wire act1 = rate1 ? ~trip1_ff :
            (mode_ff[`PCM_M_BLIP1] ? blip1_ff != 8'h00 : hit1);
wire act2 = rate2 ? ~trip2_ff :
            (mode_ff[`PCM_M_BLIP2] ? blip2_ff != 8'h00 : hit2);
assign relay1_out = mode_ff[`PCM_M_POL1] ? act1 : ~act1;
assign relay2_out = mode_ff[`PCM_M_POL2] ? act2 : ~act2;
assign nv_count1 = setpoint_events_counting_ff;
assign nv_count2 = cnt2_ff;
assign nv_prog = {prog2_ff, prog1_ff};

wire [31:0] diff = {16'h0000, sp1_ff[`PCM_LO]} - {16'h0000, setpoint_events_counting_ff};
assign remain = ($signed(diff) < $signed(`PCM_REM_MIN)) ?
                `PCM_REM_MIN : diff;
assign status = {22'h000000, trip2_ff & hold2, trip1_ff & hold1, mon_on,
                 trip2_ff, trip1_ff, hit2, hit1, relay2_out, relay1_out,
                 1'b0};

wire [31:0] pv = rate1 ? rate_ff : {16'h0000, setpoint_events_counting_ff};
wire [31:0] off = {16'h0000, rt_ff[`PCM_LO]};
wire [31:0] spn = {16'h0000, rt_ff[`PCM_HI]};
wire [31:0] frac = (spn == 32'h00000000) ? 32'h00000000 :
                   ((pv - off) * `PCM_UA_SPAN) / spn;

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      retx_ua_ff <= `PCM_UA_LO;
      fault_disp_ff <= 6'h00;
   end else begin
      if (pv <= off)
         retx_ua_ff <= `PCM_UA_LO;
      else if (pv >= off + spn)
         retx_ua_ff <= `PCM_UA_HI;
      else
         retx_ua_ff <= `PCM_UA_LO + frac[15:0];
      fault_disp_ff <= {6{mode_ff[`PCM_M_INDI]}} &
                       {trip2_ff & hold2, trip1_ff & hold1,
                        trip2_ff & why2_ff[0], trip2_ff & why2_ff[1],
                        trip1_ff & why1_ff[0], trip1_ff & why1_ff[1]};
   end
end

endmodule

// ===== dv/pcm_asserts.sv
// Port assertions for the pulse monitor
`timescale 1ns/10ps
module pcm_chk(
   // Watched ports
   input wire clk,
   input wire rst_b,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [15:0] retx_ua_ff,
   input wire nv_store_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read late");
   a_rd_drop: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("read stuck");
   a_wr_drop: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("reply stuck");
   a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read overrun");
   a_dec_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h3
      |-> s_axi_rdata == 32'h0) else $error("refused data");
   a_loop_low: assert property (retx_ua_ff >= 16'h0FA0)
      else $error("loop low");
   a_loop_high: assert property (retx_ua_ff <= 16'h4E20)
      else $error("loop high");
   a_store_once: assert property (nv_store_ff |=> !nv_store_ff)
      else $error("store long");
endmodule
bind pcm_top pcm_chk u_chk(.*);

// ===== dv/pcm_sw.sv
// Switch contact model on the pulse pin
`timescale 1ns/10ps
module pcm_sw(
   // Request in, contact out (high when shorted)
   input wire clk,
   input wire go,
   input wire [7:0] n,
   output logic pin = 1'h0,
   output logic busy
);
   int k = 0;
   // Closures spaced well apart so edge detection sees each one
   always @(posedge clk) begin
      k <= go ? n * 8 : k - (k != 0);
      pin <= (k % 8) > 4;
   end
   assign busy = k != 0;
endmodule

// ===== dv/tb.sv
// Register and pin sequence for the pulse monitor
`timescale 1ns/10ps
module tb;
   logic clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
   logic ctrl_pin_in = 0, pwr_fail_in = 0, go = 0, a, w, v;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, n = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, pulse_in, busy, relay1_out, relay2_out, nv_store_ff;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, nv_prog;
   wire [15:0] retx_ua_ff, nv_count1, nv_count2;
   wire [5:0] fault_disp_ff;
   int fails = 0, tests_run = 0, i;
   always #25 clk = ~clk;
   // Short tick and slow window keep the run brief
   pcm_top #(.TICK_CYC(24'h14), .SLOW_CYC(24'h0A)) dut(.*);
   pcm_sw sw(.clk(clk), .go(go), .n(n), .pin(pulse_in), .busy(busy));
   task close_out;
      if (fails == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("mismatch %0t got %h want %h", $time, g, e);
      end
   endtask
   task tmo;
      if (i == 60) begin
         fails++;
         $display("mismatch %0t no answer", $time);
         close_out;
      end
   endtask
   task wr(input [7:0] ad, input [31:0] d, input [1:0] r);
      {s_axi_awaddr, s_axi_wdata} <= {ad, d};
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      for (i = 0; i < 60; i++) begin
         @(negedge clk);
         {a, w, v} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
         if (v) chk(s_axi_bresp, r);
         @(posedge clk);
         if (a) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
         if (v) break;
      end
      tmo;
   endtask
   task rd(input [7:0] ad, input [31:0] d, input [1:0] r);
      {s_axi_araddr, s_axi_arvalid} <= {ad, 1'h1};
      for (i = 0; i < 60; i++) begin
         @(negedge clk);
         {a, v} = {s_axi_arready, s_axi_rvalid};
         if (v) chk(s_axi_rdata, d);
         if (v) chk(s_axi_rresp, r);
         @(posedge clk);
         if (a) s_axi_arvalid <= 1'h0;
         if (v) break;
      end
      tmo;
   endtask
   task pulse(input [7:0] k);
      {n, go} <= {k, 1'h1};
      @(posedge clk);
      go <= 1'h0;
      for (i = 0; i < 60; i++) @(negedge clk) if (!busy) break;
      tmo;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      rd(8'h04, 32'h0030F300, 2'h0);
      rd(8'h20, 32'h00010001, 2'h0);
      rd(8'h60, 32'h0, 2'h3);
      wr(8'h40, 32'h0, 2'h3);
      wr(8'h24, 32'h00010003, 2'h0);
      wr(8'h28, 32'h00010005, 2'h0);
      pulse(8'h07);
      rd(8'h38, 32'h0000000A, 2'h0);
      rd(8'h3C, 32'h00000007, 2'h0);
      chk(relay1_out, 1'h1);
      chk(relay2_out, 1'h1);
      chk(retx_ua_ff, 16'h1040);
      chk(nv_prog, 32'h00000001);
      chk(nv_count2, 16'h0007);
      pwr_fail_in <= 1'h1;
      @(posedge clk);
      @(negedge clk);
      chk(nv_store_ff, 1'h1);
      repeat (2) @(posedge clk);
      chk(nv_count1, 16'h000A);
      wr(8'h00, 32'h1, 2'h0);
      rd(8'h38, 32'h0, 2'h0);
      rd(8'h3C, 32'h7, 2'h0);
      ctrl_pin_in <= 1'h1;
      repeat (6) @(posedge clk);
      rd(8'h3C, 32'h0, 2'h0);
      wr(8'h24, 32'h00010001, 2'h0);
      wr(8'h28, 32'h00010001, 2'h0);
      wr(8'h04, 32'h0070F300, 2'h0);
      pulse(8'h06);
      rd(8'h38, 32'h3, 2'h0);
      wr(8'h10, 32'h2, 2'h0);
      wr(8'h04, 32'h0031F302, 2'h0);
      pulse(8'h06);
      repeat (250) @(negedge clk);
      chk(relay1_out, 1'h0);
      chk(relay2_out, 1'h1);
      chk(fault_disp_ff, 6'h11);
      @(posedge clk);
      ctrl_pin_in <= 1'h0;
      repeat (450) @(negedge clk);
      chk(relay1_out, 1'h1);
      close_out;
   end
endmodule
